// ---- wep_pkg.sv ----
// wep_pkg.sv: shared types and constants of the wake and power control block
package wep_pkg;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ        = 20_000_000;
  localparam int unsigned LONG_PRESS_MS = 4000;
  localparam int unsigned LONG_PRESS_CYC = (CLK_HZ / 1000) * LONG_PRESS_MS;
  localparam int unsigned PRESS_W       = 27;
  localparam int unsigned NUM_FANS      = 4;
  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_CTRL   = 4'h0;
  localparam logic [3:0] ADDR_CMD    = 4'h4;
  localparam logic [3:0] ADDR_STATUS = 4'h8;
  localparam logic [3:0] ADDR_WAKE   = 4'hC;
  localparam logic [7:0] CTRL_RST    = 8'h49;
  localparam logic [1:0] CMD_S3      = 2'h1;
  localparam logic [1:0] CMD_S4      = 2'h2;
  localparam logic [1:0] CMD_OFF     = 2'h3;
  localparam logic [1:0] MODE_ON     = 2'h1;
  localparam logic [1:0] MODE_LAST   = 2'h2;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // wake source bit positions
  localparam int unsigned W_PME  = 0;
  localparam int unsigned W_PCIE = 1;
  localparam int unsigned W_LAN  = 2;
  localparam int unsigned W_USB  = 3;
  localparam int unsigned W_PS2  = 4;
  localparam int unsigned W_RING = 5;
  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PWR_OFF = 2'h0, PWR_ON = 2'h1, PWR_S3 = 2'h3, PWR_S4 = 2'h2
  } wep_pwr_type;
  typedef struct packed {
    logic       pme_n;
    logic       pcie_wake_n;
    logic       lan_wake;
    logic       usb_act;
    logic       ps2_act;
    logic       ring;
  } wep_wake_type;
  typedef struct packed {
    logic [1:0] last_mode;
    logic       led_dual;
    logic       ring_en;
    logic       pme_s5_en;
    logic       lan_s5_en;
    logic       pme_en;
  } wep_cfg_type;
  typedef struct packed {
    wep_pwr_type        pwr;
    wep_cfg_type        cfg;
    logic [5:0]         wake_flags;
    logic [5:0]         sync1;
    logic [5:0]         sync2;
    logic               btn1;
    logic               btn2;
    logic [PRESS_W-1:0] press_cnt;
    logic               long_done;
    logic               restored;
    logic               aw_got;
    logic               w_got;
    logic [3:0]         awaddr;
    logic [7:0]         wdata;
    logic               wstrb0;
    logic               bvalid;
    logic [1:0]         bresp;
    logic               rvalid;
    logic [31:0]        rdata;
    logic [1:0]         rresp;
  } wep_state_type;
endpackage

// ---- wep_ctrl.sv ----
// wep_ctrl.sv: standby-domain power state and wake event controller
// ------------------------------------------------------------------
// Functional notes
// - fans all on in working state S0.
// - fans all off when off or in S3, S4, S5.
// - PME wakes from S3, S4, S5 only when PME wake enabled.
// - PCIe wake wakes from S3, S4 and S5.
// - USB activity wakes from S3 only.
// - PS/2 activity wakes from S3.
// - modem ring resumes from S3, only while ring interrupt unmasked.
// - LAN wake frame request powers system up.
// - after AC loss, restore prior on/off state per last-state setting.
// - power-off command drops main supply; supply keeps standby rails.
// - in S3 supply off, LED amber if dual colour, else dark.
// - enabled wake event in S3 returns system to working state.
// - standby indicator lit whenever standby power present.
// - LAN and PME wake from S5 off by default, enabled by setting.
// - short press toggles off/sleep and on; long press forces off.
// ------------------------------------------------------------------
`timescale 1ns/1ns
`default_nettype none
module wep_ctrl
  import wep_pkg::*;
#(
  parameter int unsigned HOLD_CYCLES = LONG_PRESS_CYC,
  parameter int unsigned FANS        = NUM_FANS
) (
  // clock and reset
  input  wire logic          aclk,
  input  wire logic          aresetn,
  // axi4-lite slave
  input  wire logic          s_axi_awvalid,
  output logic               s_axi_awready,
  input  wire logic [31:0]   s_axi_awaddr,
  input  wire logic          s_axi_wvalid,
  output logic               s_axi_wready,
  input  wire logic [31:0]   s_axi_wdata,
  input  wire logic [3:0]    s_axi_wstrb,
  output logic               s_axi_bvalid,
  input  wire logic          s_axi_bready,
  output logic [1:0]         s_axi_bresp,
  input  wire logic          s_axi_arvalid,
  output logic               s_axi_arready,
  input  wire logic [31:0]   s_axi_araddr,
  output logic               s_axi_rvalid,
  input  wire logic          s_axi_rready,
  output logic [31:0]        s_axi_rdata,
  output logic [1:0]         s_axi_rresp,
  // wake sources and power switch
  input  wire wep_wake_type  wake_in,
  input  wire logic          pwr_btn,
  input  wire logic          saved_on,
  // power supply and front panel
  output logic               ps_on_n,
  output logic [FANS-1:0]    fan_en,
  output logic               led_green,
  output logic               led_amber,
  output logic               stby_led,
  output logic               last_on
);
  initial begin
    if (HOLD_CYCLES < 2 || HOLD_CYCLES >= (1 << PRESS_W) || FANS < 1)
      $error("wep_ctrl: unsupported parameter values");
  end

  wep_state_type s;
  wep_state_type next_s;
  logic [5:0]    raw;
  logic [5:0]    allowed;
  logic [5:0]    hit;
  logic          wake_req;
  logic          sleeping;
  logic          long_hit;
  logic          short_rel;
  logic          wr_go;
  logic          cmd_wr;
  logic          rd_go;

  // ------------------------------------------------------------------
  // wake source qualification
  // ------------------------------------------------------------------
  assign raw = {wake_in.ring, wake_in.ps2_act, wake_in.usb_act,
                wake_in.lan_wake, ~wake_in.pcie_wake_n, ~wake_in.pme_n};
  assign sleeping = (s.pwr != PWR_ON);
  always_comb begin
    allowed = 6'h00;
    allowed[W_PME]  = s.cfg.pme_en &&
                      (s.pwr != PWR_OFF || s.cfg.pme_s5_en);
    // pcie wake from every sleep state
    allowed[W_PCIE] = sleeping;
    // lan request, gates the soft-off case
    allowed[W_LAN]  = s.pwr != PWR_OFF || s.cfg.lan_s5_en;
    allowed[W_USB]  = s.pwr == PWR_S3;
    allowed[W_PS2]  = s.pwr == PWR_S3;
    // ring needs the modem interrupt unmasked
    allowed[W_RING] = s.pwr == PWR_S3 && s.cfg.ring_en;
    if (!sleeping)
      allowed = 6'h00;
  end
  // one merged request, disallowed sources dropped
  assign hit      = s.sync2 & allowed;
  assign wake_req = |hit;
  assign long_hit = s.btn2 && !s.long_done &&
                    s.press_cnt == PRESS_W'(HOLD_CYCLES - 1);
  assign short_rel = !s.btn2 && s.press_cnt != '0 && !s.long_done;

  // ------------------------------------------------------------------
  // bus handshakes
  // ------------------------------------------------------------------
  assign s_axi_awready = !s.aw_got && !s.bvalid;
  assign s_axi_wready  = !s.w_got && !s.bvalid;
  assign s_axi_arready = !s.rvalid;
  assign wr_go  = s.aw_got && s.w_got && !s.bvalid;
  assign cmd_wr = wr_go && s.awaddr == ADDR_CMD && s.wstrb0;
  assign rd_go  = s_axi_arvalid && !s.rvalid;

  // ------------------------------------------------------------------
  // next state
  // ------------------------------------------------------------------
  always_comb begin
    next_s = s;
    // two stages, first read only by second
    next_s.sync1 = raw;
    next_s.sync2 = s.sync1;
    next_s.btn1  = pwr_btn;
    next_s.btn2  = s.btn1;
    // power switch press timing
    if (s.btn2) begin
      if (s.press_cnt != PRESS_W'(HOLD_CYCLES - 1))
        next_s.press_cnt = s.press_cnt + PRESS_W'(1);
      if (long_hit)
        next_s.long_done = 1'b1;
    end else begin
      next_s.press_cnt = '0;
      next_s.long_done = 1'b0;
    end
    // power state: restore, then long press, wake, short press, command
    if (!s.restored) begin
      next_s.restored = 1'b1;
      // last-state setting picks the power-up state
      if (s.cfg.last_mode == MODE_ON ||
          (s.cfg.last_mode == MODE_LAST && saved_on))
        next_s.pwr = PWR_ON;
    end else if (long_hit && s.pwr != PWR_OFF) begin
      next_s.pwr = PWR_OFF;
    end else if (wake_req) begin
      next_s.pwr = PWR_ON;
    end else if (short_rel) begin
      next_s.pwr = sleeping ? PWR_ON : PWR_S3;
    end else if (cmd_wr && s.pwr == PWR_ON) begin
      case (s.wdata[1:0])
        CMD_S3:  next_s.pwr = PWR_S3;
        CMD_S4:  next_s.pwr = PWR_S4;
        CMD_OFF: next_s.pwr = PWR_OFF;
        default: next_s.pwr = s.pwr;
      endcase
    end
    // write channel: address and data in either order
    if (s_axi_awvalid && s_axi_awready) begin
      next_s.aw_got = 1'b1;
      next_s.awaddr = s_axi_awaddr[3:0];
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_s.w_got  = 1'b1;
      next_s.wdata  = s_axi_wdata[7:0];
      next_s.wstrb0 = s_axi_wstrb[0];
    end
    // sticky wake flags; a new event beats the clear
    next_s.wake_flags = s.wake_flags;
    if (wr_go) begin
      next_s.aw_got = 1'b0;
      next_s.w_got  = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp  = RESP_OKAY;
      case (s.awaddr)
        ADDR_CTRL:
          if (s.wstrb0)
            next_s.cfg = wep_cfg_type'(s.wdata[6:0]);
        ADDR_CMD:    next_s.bresp = RESP_OKAY;
        ADDR_STATUS: next_s.bresp = RESP_OKAY;
        ADDR_WAKE:
          if (s.wstrb0)
            next_s.wake_flags = s.wake_flags & ~s.wdata[5:0];
        default:     next_s.bresp = RESP_SLVERR;
      endcase
    end
    next_s.wake_flags = next_s.wake_flags | (wake_req ? hit : 6'h00);
    if (s.bvalid && s_axi_bready)
      next_s.bvalid = 1'b0;
    // read channel, answer one cycle after the address
    if (rd_go) begin
      next_s.rvalid = 1'b1;
      next_s.rresp  = RESP_OKAY;
      case (s_axi_araddr[3:0])
        ADDR_CTRL:   next_s.rdata = {25'h0, s.cfg};
        ADDR_CMD:    next_s.rdata = 32'h0;
        ADDR_STATUS: next_s.rdata = {28'h0, !ps_on_n, fan_en[0], s.pwr};
        ADDR_WAKE:   next_s.rdata = {26'h0, s.wake_flags};
        default: begin
          next_s.rdata = 32'h0;
          next_s.rresp = RESP_SLVERR;
        end
      endcase
    end else if (s.rvalid && s_axi_rready) begin
      next_s.rvalid = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s            <= '0;
      s.cfg        <= wep_cfg_type'(CTRL_RST[6:0]);
    end else begin
      s <= next_s;
    end
  end

  // ------------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------------
  // fans on in S0; off otherwise
  assign fan_en    = {FANS{s.pwr == PWR_ON}};
  // supply on only when working; off in S3
  assign ps_on_n   = (s.pwr != PWR_ON);
  assign led_green = (s.pwr == PWR_ON);
  // amber in S3 for a dual-colour lamp
  assign led_amber = (s.pwr == PWR_S3) && s.cfg.led_dual;
  // lit as long as this logic has standby power
  assign stby_led  = 1'b1;
  assign last_on   = (s.pwr == PWR_ON);
  assign s_axi_bvalid = s.bvalid;
  assign s_axi_bresp  = s.bresp;
  assign s_axi_rvalid = s.rvalid;
  assign s_axi_rdata  = s.rdata;
  assign s_axi_rresp  = s.rresp;

  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_fan_working: assert property (
    s.restored && $past(wake_req) && $past(s.restored) && !$past(long_hit)
    |-> fan_en == {FANS{1'b1}})
    else $error("fans not on after wake");
  a_fan_sleep: assert property (
    $rose(ps_on_n) |-> fan_en == '0 ##1 fan_en == '0 || !ps_on_n)
    else $error("fans on while supply off");
  a_pme_gated: assert property (
    !s.cfg.pme_en && s.sync2 == 6'h01 |-> !wake_req)
    else $error("pme woke with pme wake disabled");
  a_usb_s3only: assert property (
    s.pwr != PWR_S3 && s.sync2 == 6'h08 |-> !wake_req)
    else $error("usb woke from a deep state");
  a_wake_resume: assert property (
    s.restored && wake_req && !long_hit |=> s.pwr == PWR_ON && !ps_on_n)
    else $error("wake request did not resume");
  a_s3_panel: assert property (
    s.pwr == PWR_S3 |-> ps_on_n && !led_green
                        && led_amber == s.cfg.led_dual)
    else $error("wrong supply or lamp in S3");
  a_long_press: assert property (
    s.restored && long_hit && s.pwr != PWR_OFF |=> s.pwr == PWR_OFF
    ##1 s.pwr == PWR_OFF || !s.btn2 || $past(wake_req))
    else $error("long press did not force off");
  a_off_cmd: assert property (
    s.restored && cmd_wr && s.wdata[1:0] == CMD_OFF && s.pwr == PWR_ON
    && !wake_req && !short_rel && !long_hit |=> ps_on_n && s.bvalid)
    else $error("power-off command ignored");
  a_restore_on: assert property (
    !s.restored && s.cfg.last_mode == MODE_LAST
    |=> (s.pwr == PWR_ON) == $past(saved_on))
    else $error("last-state setting not applied");
  a_stby_lit: assert property (
    stby_led)
    else $error("standby lamp dark");
  a_sync_depth: assert property (
    s.sync1 != $past(s.sync1) |=> s.sync2 == $past(s.sync1))
    else $error("wake input skipped a stage");
  a_pcie_wake: assert property (
    s.restored && sleeping && s.sync2[W_PCIE] |-> wake_req)
    else $error("pcie wake ignored while asleep");
  a_flag_set: assert property (
    wake_req |=> (s.wake_flags & $past(hit)) == $past(hit))
    else $error("wake flag lost to a clear");

  c_wake_s3:  cover property (s.pwr == PWR_S3 ##1 s.pwr == PWR_ON);
  c_long_off: cover property (long_hit && s.pwr == PWR_ON);
  c_cmd_s4:   cover property (cmd_wr && s.wdata[1:0] == CMD_S4);
  c_restore:  cover property (!s.restored ##1 s.pwr == PWR_ON);
  c_btn_wake: cover property (short_rel && s.pwr == PWR_OFF);
endmodule
`default_nettype wire

// ---- wep_psu_model.sv ----
// wep_psu_model.sv: supply and wake peripheral model for the bench
`timescale 1ns/1ns
`default_nettype none
module wep_psu_model
  import wep_pkg::*;
(
  // supply control
  input  wire logic         ps_on_n,
  // wake requests from the bench, indexed by wake bit position
  input  wire logic [5:0]   act,
  // outputs to the board
  output var  wep_wake_type wake_in,
  output logic              main_ok,
  output logic              stby_ok
);
  // ----------------------------------------------------------------
  // rails
  // ----------------------------------------------------------------
  // main rails follow enable, standby stays up
  assign main_ok = !ps_on_n;
  assign stby_ok = 1'b1;
  // ----------------------------------------------------------------
  // wake lines
  // ----------------------------------------------------------------
  // pme and pcie wake are active low on the wire
  always_comb begin
    wake_in.pme_n       = !act[W_PME];
    wake_in.pcie_wake_n = !act[W_PCIE];
    wake_in.lan_wake    = act[W_LAN];
    wake_in.usb_act     = act[W_USB];
    wake_in.ps2_act     = act[W_PS2];
    wake_in.ring        = act[W_RING];
  end
endmodule
`default_nettype wire

// ---- wake_event_power_control_test.sv ----
// wake_event_power_control_test.sv: self-checking bench of wep_ctrl
`timescale 1ns/1ns
`default_nettype none
module wake_event_power_control_test;
  import wep_pkg::*;
  logic         aclk = 1'b0, aresetn = 1'b0, btn = 1'b0, sav = 1'b0;
  logic         awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
  logic [31:0]  awa = 32'h0, wd = 32'h0, ara = 32'h0, rd, rdv;
  logic [3:0]   ws = 4'h0, fan;
  logic [5:0]   act = 6'h0;
  logic [1:0]   br, rr, rsp;
  logic         awr, wrr, bv, arr, rv, psn, lg, la, sl, lo, mok, sok;
  wep_wake_type wk;
  int           err_total = 0, n_compared = 0;
  logic [31:0]  rnd = 32'h30;
  logic [1:0]   cmds [3] = '{CMD_S3, CMD_S4, CMD_OFF};
  logic [7:0]   c;
  logic [1:0]   m;
  logic         e;
  int           s;
  always #25 aclk = ~aclk;
  wep_ctrl #(.HOLD_CYCLES(20), .FANS(4)) i_dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa),
    .s_axi_wvalid(wv), .s_axi_wready(wrr), .s_axi_wdata(wd),
    .s_axi_wstrb(ws), .s_axi_bvalid(bv), .s_axi_bready(bry),
    .s_axi_bresp(br), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_araddr(ara), .s_axi_rvalid(rv), .s_axi_rready(rry),
    .s_axi_rdata(rd), .s_axi_rresp(rr), .wake_in(wk), .pwr_btn(btn),
    .saved_on(sav), .ps_on_n(psn), .fan_en(fan), .led_green(lg),
    .led_amber(la), .stby_led(sl), .last_on(lo));
  wep_psu_model i_psu (.ps_on_n(psn), .act(act), .wake_in(wk),
    .main_ok(mok), .stby_ok(sok));
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    xs = v ^ (v << 5);
  endfunction
  // expected wake by source, sleep command and control word
  function automatic logic ew(input int s, input logic [1:0] m,
                              input logic [7:0] c);
    case (s)
      W_PME:   ew = c[0] && (m != CMD_OFF || c[2]);
      W_PCIE:  ew = 1'b1;
      W_LAN:   ew = m != CMD_OFF || c[1];
      W_RING:  ew = m == CMD_S3 && c[3];
      default: ew = m == CMD_S3;
    endcase
  endfunction
  task automatic chk(input string n, input logic [31:0] x, g);
    n_compared++;
    if (g !== x) begin
      err_total++;
      $display("BAD %s expected %h seen %h", n, x, g);
    end
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // address and data go out together, released one by one when taken
  task automatic wr(input logic [31:0] a, d);
    @(posedge aclk);
    awv <= 1'b1; awa <= a; wv <= 1'b1; wd <= d; ws <= 4'hF; bry <= 1'b1;
    repeat (100) begin
      @(posedge aclk);
      if (awv && awr) awv <= 1'b0;
      if (wv && wrr) wv <= 1'b0;
      if (bv) begin
        rsp = br;
        bry <= 1'b0;
        return;
      end
    end
    chk("bvalid", 1, 0);
  endtask
  task automatic rdr(input logic [31:0] a);
    @(posedge aclk);
    arv <= 1'b1; ara <= a; rry <= 1'b1;
    repeat (100) begin
      @(posedge aclk);
      if (arv && arr) arv <= 1'b0;
      if (rv) begin
        rdv = rd;
        rsp = rr;
        rry <= 1'b0;
        return;
      end
    end
    chk("rvalid", 1, 0);
  endtask
  task automatic rst(input logic v);
    @(posedge aclk);
    aresetn <= 1'b0;
    sav <= v;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
    #1;
  endtask
  task automatic press(input int n);
    @(posedge aclk);
    btn <= 1'b1;
    repeat (n) @(posedge aclk);
    btn <= 1'b0;
    repeat (8) @(posedge aclk);
    #1;
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    rst(1'b0);
    chk("stby_led", 1, sl);
    chk("standby rail", 1, sok);
    chk("ps_on_n after loss", 1, psn);
    rdr(ADDR_CTRL);
    chk("ctrl reset", CTRL_RST, rdv);
    // only the low address bits decode; a misaligned offset hits nothing
    rdr(32'h6);
    chk("unmapped resp", RESP_SLVERR, rsp);
    chk("unmapped data", 0, rdv);
    press(3);
    chk("fans on", 4'hF, fan);
    chk("green", 1, lg);
    // every source against every sleep state, random control word
    for (int it = 0; it < 18; it++) begin
      rnd = xs(rnd);
      c = {1'b0, MODE_LAST, rnd[4:0]};
      s = it % 6;
      m = cmds[it / 6];
      wr(ADDR_CTRL, {24'h0, c});
      chk("bresp", RESP_OKAY, rsp);
      wr(ADDR_CMD, {30'h0, m});
      rdr(ADDR_STATUS);
      chk("status", (m == CMD_S3) ? 3 : (m == CMD_S4) ? 2 : 0, rdv);
      chk("fans off", 0, fan);
      chk("main rails", 0, mok);
      if (m == CMD_S3) chk("amber", c[4], la);
      e = ew(s, m, c);
      @(posedge aclk);
      act <= 6'h1 << s;
      repeat (2) @(posedge aclk);
      #1 chk("sync delay", 1, psn);
      @(posedge aclk);
      #1 chk("wake", !e, psn);
      act <= 6'h0;
      if (e) begin
        rdr(ADDR_WAKE);
        chk("wake flag", 32'h1 << s, rdv);
      end else begin
        @(posedge aclk);
        act <= 6'h1 << W_PCIE;
        repeat (4) @(posedge aclk);
        act <= 6'h0;
      end
      wr(ADDR_WAKE, 32'h3F);
      rdr(ADDR_WAKE);
      chk("wake clear", 0, rdv);
      chk("fans back", 4'hF, fan);
      chk("main rails on", 1, mok);
    end
    // long hold forces off; release after that does nothing
    @(posedge aclk);
    btn <= 1'b1;
    repeat (28) @(posedge aclk);
    #1 chk("long press", 1, psn);
    btn <= 1'b0;
    repeat (8) @(posedge aclk);
    #1 chk("long release", 1, psn);
    rst(1'b1);
    chk("restore on", 0, psn);
    chk("last_on", 1, lo);
    final_report();
  end
  // hang guard, far beyond the few hundred cycles the run needs
  initial begin
    #2_000_000;
    err_total++;
    $display("BAD watchdog expected done seen hang");
    final_report();
  end
endmodule
`default_nettype wire
